// file: shared/scd_pkg.sv
package scd_pkg;

  // frame layout
  localparam int          FRAME_BITS  = 16;
  localparam int          POS_RW      = 15;
  localparam int          POS_SEL_HI  = 14;
  localparam int          POS_SEL_LO  = 13;
  localparam int          DATA_BITS   = 13;
  localparam logic [4:0]  CNT_FRAME   = 5'h10;
  localparam logic [4:0]  CNT_CAP     = 5'h11;
  localparam logic [4:0]  CNT_RESET   = 5'h00;
  localparam int          SYNC_STAGES = 2;

  // register select codes
  localparam logic [1:0]  SEL_CMD     = 2'h0;
  localparam logic [1:0]  SEL_DIAG    = 2'h1;
  localparam logic [1:0]  SEL_STAT    = 2'h2;
  localparam logic [1:0]  SEL_NONE    = 2'h3;

  // command register fields
  localparam int          CMD_CH2     = 0;
  localparam int          CMD_CH4     = 1;
  localparam int          CMD_CH5     = 2;
  localparam int          CMD_LOAD_LO = 9;
  localparam int          CMD_THR_LO  = 11;
  localparam logic [12:0] CMD_RESET   = 13'h0000;
  localparam logic [12:0] CMD_WMASK   = 13'h1e07;

  // diagnosis register fields
  localparam int          DG_CH_ONE_OPEN_LOAD   = 0;
  localparam int          DG_CH_ONE_OVERCURRENT   = 1;
  localparam int          DG_CH_ONE_OVERTEMP   = 2;
  localparam int          DG_CH_TWO_OVERCURRENT   = 3;
  localparam int          DG_CH_TWO_OVERTEMP   = 4;
  localparam int          DG_CH_THREE_OPEN_LOAD   = 5;
  localparam int          DG_CH_THREE_OVERCURRENT   = 6;
  localparam int          DG_CH_THREE_OVERTEMP   = 7;
  localparam int          DG_CH_FOUR_OPEN_LOAD   = 8;
  localparam int          DG_CH_FOUR_OVERCURRENT   = 9;
  localparam int          DG_CH_FIVE_OPEN_LOAD   = 10;
  localparam int          DG_CH_FIVE_OVERCURRENT   = 11;
  localparam int          DG_CH_FOUR_FIVE_OVERTEMP  = 12;
  localparam logic [12:0] DIAG_RESET  = 13'h0000;
  localparam logic [15:0] RESP_RESET  = 16'h0000;

  typedef struct packed {
    logic       rw;
    logic [1:0] sel;
    logic [12:0] data;
  } scd_frame_t;

  typedef enum logic [1:0] {
    LOAD_75K = 2'h0,
    LOAD_4K5 = 2'h1,
    LOAD_2K2 = 2'h2,
    LOAD_1K2 = 2'h3
  } scd_load_t;

  typedef enum logic [1:0] {
    THR_50MV  = 2'h0,
    THR_100MV = 2'h1,
    THR_500MV = 2'h2,
    THR_1V    = 2'h3
  } scd_thr_t;

  typedef struct packed {
    scd_thr_t   threshold;
    scd_load_t  load;
    logic [5:0] spare;
    logic       ch5;
    logic       ch4;
    logic       ch2;
  } scd_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_EXEC   = 3'b100
  } scd_state_t;

endpackage

// file: rtl/scd_fault_flags.sv
`timescale 1ns/100ps
// sticky fault flags: each raw fault is synchronised, then latched until a
// diagnosis read finds the condition gone; a live condition always wins
module scd_fault_flags #(
  parameter int N = 13
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_cken,
  // fault levels from the power stages
  input  wire logic [N-1:0] i_fault_raw,
  // one-cycle pulse on a diagnosis read
  input  wire logic         i_read_clr,
  // latched flags
  output logic      [N-1:0] o_flags
);

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          o_flags[g] <= 1'b0;
        end else if (i_cken) begin
          sync1_r[g] <= i_fault_raw[g];
          sync2_r[g] <= sync1_r[g];
          o_flags[g] <= sync2_r[g] | (o_flags[g] & ~i_read_clr);
        end
      end
    end
  endgenerate

  chk_flag_sets : assert property (@(posedge i_mclk) disable iff (i_rst)
    i_cken |=> ((o_flags & $past(sync2_r)) == $past(sync2_r)))
    else $error("fault flag did not set on a live condition");

  chk_flag_holds : assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_cken && !i_read_clr) |=> ((o_flags & $past(o_flags)) == $past(o_flags)))
    else $error("fault flag dropped without a diagnosis read");

endmodule

// file: rtl/scd_spi_regs.sv
`timescale 1ns/100ps
// Functional notes
// - next frame returns the register last addressed
// - invalid frame: next frame returns diagnosis
// - bit 15 direction, bits 14:13 register select
// - command bits 0..2 switch channels 2,4,5
// - command bits 10:9 select sensor load
// - command bits 12:11 select sensor threshold
// - open load channels 1,3 at bits 0,5
// - overcurrent channels 1,2,3 at bits 1,3,6
// - overtemperature channels 1,2,3 at bits 2,4,7
// - shared overtemperature channels 4,5 at bit 12
// - open load channels 4,5 at bits 8,10
// - overcurrent channels 4,5 at bits 9,11
// - diagnosis flags read-only, zero after reset
// - only sixteen-bit frames execute, others discarded
// - response echoes direction and select bits
// - flags clear on diagnosis read once fault gone
module scd_spi_regs (
  // system clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_cken,
  // serial link
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  output logic             o_so,
  output logic             o_so_oe,
  // fault levels from the power stages
  input  wire logic        i_ch_one_open_load,
  input  wire logic        i_ch_one_overcurrent,
  input  wire logic        i_ch_one_overtemp,
  input  wire logic        i_ch_two_overcurrent,
  input  wire logic        i_ch_two_overtemp,
  input  wire logic        i_ch_three_open_load,
  input  wire logic        i_ch_three_overcurrent,
  input  wire logic        i_ch_three_overtemp,
  input  wire logic        i_ch_four_open_load,
  input  wire logic        i_ch_four_overcurrent,
  input  wire logic        i_ch_five_open_load,
  input  wire logic        i_ch_five_overcurrent,
  input  wire logic        i_ch_four_five_overtemp,
  // status register content from surrounding logic
  input  wire logic [12:0] i_status_bits,
  // command register outputs
  output logic             o_channel_two_on,
  output logic             o_channel_four_on,
  output logic             o_channel_five_on,
  output logic [1:0]       o_sensor_load_select,
  output logic [1:0]       o_sensor_threshold_select
);

  // ---------------- link clock domain ----------------
  logic              link_rst;
  logic              neg_seen_r;
  logic              pos_seen_r;
  logic [15:0]       rx_r;
  logic [15:0]       rx_nxt;
  logic [4:0]        cnt_r;
  logic [4:0]        cnt_nxt;
  logic              tag_r;
  logic [15:0]       tx_sh_r;
  logic              so_bit_r;

  // ---------------- system clock domain ----------------
  logic              cs_sync1_r;
  logic              cs_sync2_r;
  scd_pkg::scd_state_t state_r;
  scd_pkg::scd_state_t state_nxt;
  logic              parity_r;
  logic              flag_r;
  logic              oe_r;
  logic [15:0]       resp_r;
  logic [15:0]       resp_nxt;
  scd_pkg::scd_cmd_t cmd_r;
  scd_pkg::scd_cmd_t cmd_nxt;
  logic [12:0]       diag;
  logic [12:0]       fault_raw;

  wire scd_pkg::scd_frame_t req        = scd_pkg::scd_frame_t'(rx_r);
  wire                      frame_end  = (state_r == scd_pkg::ST_EXEC) && i_cken;
  wire                      len_ok     = (cnt_r == scd_pkg::CNT_FRAME) && (tag_r == parity_r);
  wire                      acc_ok     = req.rw ? (req.sel == scd_pkg::SEL_CMD) : (req.sel != scd_pkg::SEL_NONE);
  wire                      valid      = len_ok && acc_ok;
  wire                      do_write   = frame_end && valid && req.rw;
  wire                      diag_read  = frame_end && valid && !req.rw && (req.sel == scd_pkg::SEL_DIAG);
  wire [12:0]               cmd_word   = cmd_r;
  wire [12:0]               cmd_new    = cmd_nxt;
  wire                      any_fault  = |diag;

  // edge flags and transmit shifter are held in reset while chip select is high
  assign link_rst = i_rst | i_cs_n;

  // ---- receive on falling edge of the serial clock ----
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      neg_seen_r <= 1'b0;
    end else begin
      neg_seen_r <= 1'b1;
    end
  end

  // first falling edge of a frame restarts the count and the shifter
  assign cnt_nxt = !neg_seen_r ? 5'h01 :
                   (cnt_r == scd_pkg::CNT_CAP) ? scd_pkg::CNT_CAP : 5'(cnt_r + 5'h01);
  assign rx_nxt  = neg_seen_r ? {rx_r[14:0], i_si} : {15'h0000, i_si};

  // shifter, count and tag stay put while chip select is high, so the system
  // side can read them quasi-statically after it has seen chip select rise
  always_ff @(negedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      rx_r  <= 16'h0000;
      cnt_r <= scd_pkg::CNT_RESET;
      tag_r <= 1'b0;
    end else begin
      rx_r  <= rx_nxt;
      cnt_r <= cnt_nxt;
      tag_r <= parity_r;
    end
  end

  // ---- transmit on rising edge of the serial clock ----
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      pos_seen_r <= 1'b0;
      so_bit_r   <= 1'b0;
      tx_sh_r    <= 16'h0000;
    end else if (!pos_seen_r) begin
      pos_seen_r <= 1'b1;
      so_bit_r   <= resp_r[scd_pkg::POS_RW];
      tx_sh_r    <= {resp_r[14:0], 1'b0};
    end else begin
      so_bit_r   <= tx_sh_r[15];
      tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
    end
  end

  // until the first rising edge the pin shows the any-fault flag
  assign o_so    = pos_seen_r ? so_bit_r : flag_r;
  assign o_so_oe = oe_r;

  // ---- chip select synchroniser and frame sequencer ----
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync1_r <= 1'b1;
      cs_sync2_r <= 1'b1;
    end else if (i_cken) begin
      cs_sync1_r <= i_cs_n;
      cs_sync2_r <= cs_sync1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      scd_pkg::ST_IDLE: begin
        if (!cs_sync2_r) begin
          state_nxt = scd_pkg::ST_ACTIVE;
        end
      end
      scd_pkg::ST_ACTIVE: begin
        if (cs_sync2_r) begin
          state_nxt = scd_pkg::ST_EXEC;
        end
      end
      scd_pkg::ST_EXEC: begin
        state_nxt = scd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = scd_pkg::ST_IDLE;
      end
    endcase
  end

  // ---- command register ----
  always_comb begin
    cmd_nxt = cmd_r;
    if (do_write) begin
      cmd_nxt = scd_pkg::scd_cmd_t'(req.data & scd_pkg::CMD_WMASK);
    end
  end

  // ---- response word for the next frame ----
  always_comb begin
    resp_nxt = resp_r;
    if (frame_end) begin
      if (!valid) begin
        resp_nxt = {1'b0, scd_pkg::SEL_DIAG, diag};
      end else begin
        unique case (req.sel)
          scd_pkg::SEL_CMD:  resp_nxt = {req.rw, req.sel, cmd_new};
          scd_pkg::SEL_DIAG: resp_nxt = {req.rw, req.sel, diag};
          scd_pkg::SEL_STAT: resp_nxt = {req.rw, req.sel, i_status_bits};
          default:           resp_nxt = {1'b0, scd_pkg::SEL_DIAG, diag};
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r  <= scd_pkg::ST_IDLE;
      parity_r <= 1'b0;
      flag_r   <= 1'b0;
      oe_r     <= 1'b0;
      resp_r   <= scd_pkg::RESP_RESET;
      cmd_r    <= scd_pkg::scd_cmd_t'(scd_pkg::CMD_RESET);
    end else if (i_cken) begin
      state_r  <= state_nxt;
      oe_r     <= !cs_sync2_r;
      resp_r   <= resp_nxt;
      cmd_r    <= cmd_nxt;
      if (frame_end) begin
        parity_r <= !parity_r;
      end
      if (cs_sync2_r) begin
        flag_r <= any_fault;
      end
    end
  end

  // ---- command outputs ----
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_channel_two_on          <= 1'b0;
      o_channel_four_on         <= 1'b0;
      o_channel_five_on         <= 1'b0;
      o_sensor_load_select      <= scd_pkg::LOAD_75K;
      o_sensor_threshold_select <= scd_pkg::THR_50MV;
    end else if (i_cken) begin
      o_channel_two_on          <= cmd_word[scd_pkg::CMD_CH2];
      o_channel_four_on         <= cmd_word[scd_pkg::CMD_CH4];
      o_channel_five_on         <= cmd_word[scd_pkg::CMD_CH5];
      o_sensor_load_select      <= cmd_word[scd_pkg::CMD_LOAD_LO +: 2];
      o_sensor_threshold_select <= cmd_word[scd_pkg::CMD_THR_LO +: 2];
    end
  end

  // ---- diagnosis register ----
  always_comb begin
    fault_raw                         = scd_pkg::DIAG_RESET;
    fault_raw[scd_pkg::DG_CH_ONE_OPEN_LOAD]     = i_ch_one_open_load;
    fault_raw[scd_pkg::DG_CH_THREE_OPEN_LOAD]     = i_ch_three_open_load;
    fault_raw[scd_pkg::DG_CH_ONE_OVERCURRENT]     = i_ch_one_overcurrent;
    fault_raw[scd_pkg::DG_CH_TWO_OVERCURRENT]     = i_ch_two_overcurrent;
    fault_raw[scd_pkg::DG_CH_THREE_OVERCURRENT]     = i_ch_three_overcurrent;
    fault_raw[scd_pkg::DG_CH_ONE_OVERTEMP]     = i_ch_one_overtemp;
    fault_raw[scd_pkg::DG_CH_TWO_OVERTEMP]     = i_ch_two_overtemp;
    fault_raw[scd_pkg::DG_CH_THREE_OVERTEMP]     = i_ch_three_overtemp;
    fault_raw[scd_pkg::DG_CH_FOUR_FIVE_OVERTEMP]    = i_ch_four_five_overtemp;
    fault_raw[scd_pkg::DG_CH_FOUR_OPEN_LOAD]     = i_ch_four_open_load;
    fault_raw[scd_pkg::DG_CH_FIVE_OPEN_LOAD]     = i_ch_five_open_load;
    fault_raw[scd_pkg::DG_CH_FOUR_OVERCURRENT]     = i_ch_four_overcurrent;
    fault_raw[scd_pkg::DG_CH_FIVE_OVERCURRENT]     = i_ch_five_overcurrent;
  end

  // flags never take host data: only faults set them, reads clear them
  scd_fault_flags #(
    .N (scd_pkg::DATA_BITS)
  ) u_flags (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_cken      (i_cken),
    .i_fault_raw (fault_raw),
    .i_read_clr  (diag_read),
    .o_flags     (diag)
  );

  // ---------------- checks ----------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_frame_done;
    frame_end && len_ok;
  endsequence

  sequence s_good_write;
    s_frame_done ##0 (req.rw && req.sel == scd_pkg::SEL_CMD);
  endsequence

  sequence s_good_read;
    s_frame_done ##0 (!req.rw && req.sel != scd_pkg::SEL_NONE);
  endsequence

  chk_read_answer : assert property (s_good_read |=>
    (resp_r[scd_pkg::POS_SEL_HI:scd_pkg::POS_SEL_LO] == $past(req.sel)))
    else $error("read answer does not name the addressed register");

  chk_invalid_diag : assert property ((frame_end && !valid) |=>
    (resp_r == {1'b0, scd_pkg::SEL_DIAG, $past(diag)}))
    else $error("invalid frame not answered with diagnosis");

  chk_write_channels : assert property (s_good_write |=> ##1
    ({o_channel_five_on, o_channel_four_on, o_channel_two_on} == $past(req.data[2:0], 2)))
    else $error("channel bits do not follow the write");

  chk_sensor_fields : assert property (s_good_write |=> ##1
    ({o_sensor_threshold_select, o_sensor_load_select} == $past(req.data[12:9], 2)))
    else $error("sensor load or threshold does not follow the write");

  chk_spare_zero : assert property ((cmd_word[8:3] == 6'h00) &&
    (!$past(frame_end) || resp_r[8:3] == 6'h00 || resp_r[14:13] != scd_pkg::SEL_CMD))
    else $error("spare command bits not zero");

  chk_bad_length : assert property ((frame_end && !len_ok) |=>
    ($stable(cmd_r) && resp_r[14:13] == scd_pkg::SEL_DIAG))
    else $error("frame of wrong length was executed");

  chk_idle_flag : assert property ((cs_sync2_r && i_cken) |=> (flag_r == $past(any_fault)))
    else $error("status flag does not track the diagnosis register");

  chk_echo_bits : assert property ((frame_end && valid) |=>
    (resp_r[15:13] == {$past(req.rw), $past(req.sel)}))
    else $error("answer does not echo direction and select");

  chk_exec_once : assert property ((state_r == scd_pkg::ST_EXEC && i_cken) |=>
    (state_r == scd_pkg::ST_IDLE) ##1 !frame_end)
    else $error("frame executed more than once");

  chk_write_cmd_reg : assert property (s_good_write |=>
    (cmd_word == $past(req.data & scd_pkg::CMD_WMASK)))
    else $error("command register does not hold the masked write data");

  chk_write_answer : assert property (s_good_write |=>
    (resp_r == {3'b100, $past(req.data & scd_pkg::CMD_WMASK)}))
    else $error("write answer does not show the new command value");

  chk_refused_hold : assert property ((frame_end && !valid) |=>
    $stable(cmd_r))
    else $error("refused frame changed the command register");

  chk_status_answer : assert property ((s_good_read ##0 (req.sel == scd_pkg::SEL_STAT)) |=>
    (resp_r[12:0] == $past(i_status_bits)))
    else $error("status read answer does not carry the status bits");

  chk_diag_answer : assert property (diag_read |=>
    (resp_r == {1'b0, scd_pkg::SEL_DIAG, $past(diag)}))
    else $error("diagnosis answer does not hold the flags seen before the clear");

  chk_resp_stands : assert property (!frame_end |=>
    $stable(resp_r))
    else $error("response word changed outside a frame execution");

endmodule

// file: dv/scd_host_model.sv
`timescale 1ns/100ps
// host side of the serial link: sclk idles low, data changes on sclk rise,
// returned bits are taken on sclk fall
module scd_host_model (
  // serial link as seen by the host
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // one frame of n clocks, msb first; pre is the level seen before the first clock
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx, output logic pre);
    rx = 16'h0000;
    #7;
    o_cs_n = 1'b0;
    #160;
    pre = i_so_oe ? i_so : ~i_so;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b1;
      o_si   = (i < 16) ? tx[15-i] : ~o_si;
      #16;
      o_sclk = 1'b0;
      if (i < 16) begin
        rx[15-i] = i_so_oe ? i_so : ~i_so;
      end
      #16;
    end
    // sclk is already low at the chip-select edge
    o_cs_n = 1'b1;
    o_si   = 1'b0;
    // gap long enough for the frame to execute before the next one
    #400;
  endtask
endmodule

// file: dv/spi_control_diag_registers_tb.sv
`timescale 1ns/100ps
`define CMP(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module spi_control_diag_registers_tb;
  logic        i_mclk;
  logic        i_rst;
  logic        i_cken;
  wire         sclk;
  wire         cs_n;
  wire         si;
  logic        o_so;
  logic        o_so_oe;
  logic [12:0] flt;
  logic [12:0] status;
  logic        ch2;
  logic        ch4;
  logic        ch5;
  logic [1:0]  load;
  logic [1:0]  thr;
  int          n_mismatch;
  int          checks;
  logic [31:0] seed;
  logic [31:0] r;
  logic [12:0] cmd_m;
  logic [12:0] sticky;
  logic [15:0] prev;

  scd_spi_regs u_dut (
    .i_mclk                    (i_mclk),
    .i_rst                     (i_rst),
    .i_cken                    (i_cken),
    .i_sclk                    (sclk),
    .i_cs_n                    (cs_n),
    .i_si                      (si),
    .o_so                      (o_so),
    .o_so_oe                   (o_so_oe),
    .i_ch_one_open_load        (flt[0]),
    .i_ch_one_overcurrent      (flt[1]),
    .i_ch_one_overtemp         (flt[2]),
    .i_ch_two_overcurrent      (flt[3]),
    .i_ch_two_overtemp         (flt[4]),
    .i_ch_three_open_load      (flt[5]),
    .i_ch_three_overcurrent    (flt[6]),
    .i_ch_three_overtemp       (flt[7]),
    .i_ch_four_open_load       (flt[8]),
    .i_ch_four_overcurrent     (flt[9]),
    .i_ch_five_open_load       (flt[10]),
    .i_ch_five_overcurrent     (flt[11]),
    .i_ch_four_five_overtemp   (flt[12]),
    .i_status_bits             (status),
    .o_channel_two_on          (ch2),
    .o_channel_four_on         (ch4),
    .o_channel_five_on         (ch5),
    .o_sensor_load_select      (load),
    .o_sensor_threshold_select (thr)
  );

  scd_host_model u_host (
    .o_sclk  (sclk),
    .o_cs_n  (cs_n),
    .o_si    (si),
    .i_so    (o_so),
    .i_so_oe (o_so_oe)
  );

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one frame, then the model's view of what the next frame returns
  task automatic frame(input logic [15:0] f, input int n);
    logic [15:0] rx;
    logic        pre;
    logic        ok;
    ok = (n == 16) && (f[15] ? (f[14:13] == scd_pkg::SEL_CMD) : (f[14:13] != scd_pkg::SEL_NONE));
    u_host.xfer(f, n, rx, pre);
    `CMP(pre, |sticky)
    if (n >= 16) `CMP(rx, prev)
    else if (n == 15) `CMP(rx[15:1], prev[15:1])
    if (!ok) begin
      prev = {3'b001, sticky};
    end else if (f[15]) begin
      cmd_m = f[12:0] & 13'h1e07;
      prev  = {3'b100, cmd_m};
    end else if (f[14:13] == scd_pkg::SEL_CMD) begin
      prev = {3'b000, cmd_m};
    end else if (f[14:13] == scd_pkg::SEL_DIAG) begin
      prev   = {3'b001, sticky};
      sticky = flt;
    end else begin
      prev = {3'b010, status};
    end
    `CMP({ch5, ch4, ch2}, cmd_m[2:0])
    `CMP(load, cmd_m[10:9])
    `CMP(thr, cmd_m[12:11])
    `CMP(o_so_oe, 1'b0)
  endtask

  task automatic set_faults(input logic [12:0] v);
    @(posedge i_mclk);
    flt <= v;
    repeat (6) @(posedge i_mclk);
    sticky = sticky | v;
  endtask

  initial begin
    i_rst      = 1'b1;
    i_cken     = 1'b1;
    flt        = 13'h0000;
    status     = 13'h0000;
    seed       = 32'h5206;
    cmd_m      = 13'h0000;
    sticky     = 13'h0000;
    prev       = 16'h0000;
    n_mismatch = 0;
    checks     = 0;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    `CMP({ch5, ch4, ch2, load, thr}, 7'h00)
    frame(16'h0000, 16);
    // every load and threshold code with random channel and spare bits
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      frame({3'b100, i[3:2], i[1:0], r[5:0], r[8:6]}, 16);
      frame(16'h0000, 16);
    end
    frame(16'h9fff, 16);
    // refused accesses and wrong lengths leave the command value alone
    frame(16'hffff, 16);
    frame(16'ha123, 16);
    frame(16'hc000, 16);
    frame(16'h6000, 16);
    frame(16'h8000, 15);
    frame(16'h8000, 17);
    frame(16'h8000, 0);
    // walk each fault input, then random patterns; one pattern stays live
    for (int i = 0; i < 17; i++) begin
      r = rnd();
      set_faults((i < 13) ? (13'h0001 << i) : r[12:0]);
      @(posedge i_mclk);
      if (i != 14) begin
        flt <= 13'h0000;
      end
      frame(16'h2000, 16);
      frame(16'h2000, 16);
    end
    // a fault pulse while the clock enable is low must never latch
    @(posedge i_mclk);
    i_cken <= 1'b0;
    flt    <= 13'h0155;
    repeat (6) @(posedge i_mclk);
    flt    <= 13'h0000;
    repeat (3) @(posedge i_mclk);
    i_cken <= 1'b1;
    repeat (3) @(posedge i_mclk);
    frame(16'h2000, 16);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      @(posedge i_mclk);
      status <= r[12:0];
      frame(16'h4000, 16);
    end
    frame(16'h4000, 16);
    set_faults(13'h1fff);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    `CMP({ch5, ch4, ch2, load, thr, o_so_oe}, 8'h00)
    flt    <= 13'h0000;
    i_rst  <= 1'b0;
    cmd_m  = 13'h0000;
    sticky = 13'h0000;
    prev   = 16'h0000;
    repeat (4) @(posedge i_mclk);
    frame(16'h2000, 16);
    frame(16'h0000, 16);
    frame(16'h0000, 16);
    finish_test();
  end

  initial begin
    #(20000 * 40);
    n_mismatch++;
    finish_test();
  end
endmodule
